// ### modbus_params.svh
// Purpose: constants of the modbus function handler
// Assumes: included by the design modules
// Notes: values are counts, codes and limits of the request decoder
`ifndef MODBUS_PARAMS_SVH
`define MODBUS_PARAMS_SVH

// ****************************************
// function codes
// ****************************************
`define FC_READ_COILS 8'h01
`define FC_READ_INPUTS 8'h02
`define FC_READ_HOLD 8'h03
`define FC_WRITE_COIL 8'h05
`define FC_WRITE_REG 8'h06
`define FC_DIAG 8'h08
`define FC_WRITE_COILS 8'h0f
`define FC_WRITE_REGS 8'h10

// ****************************************
// exception codes
// ****************************************
`define EXC_NONE 8'h00
`define EXC_FUNC 8'h01
`define EXC_ADDR 8'h02
`define EXC_VALUE 8'h03
`define EXC_FLAG 8'h80

// ****************************************
// limits and values
// ****************************************
`define MAX_REGS 16'h007d
`define MAX_BITS 16'h0010
`define BIT_RANGE 17'h00010
`define DIAG_LOOPBACK 16'h0000
`define COIL_ON 16'hff00
`define COIL_OFF 16'h0000
`define HOLD_COUNT 64
`define HOLD_LIMIT 16'h0040
`define HOLD_AW 6
`define DUMMY_WORD 16'h0000

`endif

// ### modbus_pkg.sv
// Purpose: types shared by the modbus function handler
// Assumes: modbus_params.svh holds the numbers
// Notes: state of the handler is one packed struct
package modbus_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WREGS,
    ST_WCOILS,
    ST_HDR,
    ST_DATA
  } state_t;

  typedef struct packed {
    state_t state;
    logic [7:0] func;
    logic [7:0] exc;
    logic [15:0] addr;
    logic [15:0] qty;
    logic [15:0] val;
    logic [6:0] cnt;
    logic cmd_pulse;
    logic [15:0] cmd_coil;
    logic wr_en;
    logic [15:0] wr_addr;
    logic [15:0] wr_data;
  } hstate_t;

endpackage : modbus_pkg

// ### hold_regs.sv
// Purpose: holding register storage with dummy fill past the end
// Assumes: one write port, one asynchronous read port
// Notes: writes beyond the array are dropped silently
`timescale 1ns/10ps
`include "modbus_params.svh"
module hold_regs
  import modbus_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [15:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic [15:0] rd_addr,
  output logic [15:0] rd_data
);

  logic [15:0] mem [`HOLD_COUNT];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < `HOLD_COUNT; i++) begin
        mem[i] <= 16'h0000;
      end
    end else if (wr_en && (wr_addr < `HOLD_LIMIT)) begin
      mem[wr_addr[`HOLD_AW-1:0]] <= wr_data;
    end
  end

  // positions that do not exist still answer, with the dummy word
  always_comb begin
    if (rd_addr < `HOLD_LIMIT) begin
      rd_data = mem[rd_addr[`HOLD_AW-1:0]];
    end else begin
      rd_data = `DUMMY_WORD;
    end
  end

endmodule : hold_regs

// ### modbus_slave_function_handler.sv
// Purpose: dispatch decoded modbus requests and build the answers
// Assumes: framing, crc and slave-address match are done upstream
// Notes: answers leave as a header beat then data beats
//
// Function
// - coil status reads of up to 16 points, all below address 16, answer all zero
// - input status reads of up to 16 points, all below address 16, answer all zero
// - holding register reads return stored words, at most 125
// - single coil write ON fires the command of that coil
// - single register write stores the value at the address if it is below 64
// - diagnostics only supports loop-back, echoing data unchanged
// - loop-back answer always carries exactly one data register
// - multiple coil write, max 16, acts only on first coil
// - multiple register write, max 125, stores every value addressed below 64
// - broadcast requests are never acted upon nor answered
// - reads past existing registers answer full count with dummies
// - unsupported function codes answer illegal-function exception
// - coil write OFF is acknowledged but fires no command
// - requests with reception errors get no answer at all
`timescale 1ns/10ps
`include "modbus_params.svh"
module modbus_slave_function_handler
  import modbus_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_qty,
  input wire logic [15:0] req_value,
  input wire logic req_broadcast,
  input wire logic req_bad,
  input wire logic dat_valid,
  output logic dat_ready,
  input wire logic [15:0] dat_word,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic rsp_hdr,
  output logic rsp_last,
  output logic [15:0] rsp_word,
  output logic cmd_pulse,
  output logic [15:0] cmd_coil
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] check_req(input logic [7:0] f, input logic [15:0] a,
                                           input logic [15:0] q, input logic [15:0] v);
    logic [16:0] span;
    span = {1'b0, a} + {1'b0, q};
    unique case (f)
      `FC_READ_COILS, `FC_READ_INPUTS: begin
        if ((q == 16'h0000) || (q > `MAX_BITS)) check_req = `EXC_VALUE;
        else if (span > `BIT_RANGE) check_req = `EXC_ADDR;
        else check_req = `EXC_NONE;
      end
      `FC_READ_HOLD, `FC_WRITE_REGS: begin
        if ((q == 16'h0000) || (q > `MAX_REGS)) check_req = `EXC_VALUE;
        else check_req = `EXC_NONE;
      end
      `FC_WRITE_COILS: begin
        if ((q == 16'h0000) || (q > `MAX_BITS)) check_req = `EXC_VALUE;
        else check_req = `EXC_NONE;
      end
      `FC_WRITE_COIL: begin
        if ((v != `COIL_ON) && (v != `COIL_OFF)) check_req = `EXC_VALUE;
        else check_req = `EXC_NONE;
      end
      `FC_WRITE_REG: check_req = `EXC_NONE;
      `FC_DIAG: begin
        if (a != `DIAG_LOOPBACK) check_req = `EXC_FUNC;
        else check_req = `EXC_NONE;
      end
      default: check_req = `EXC_FUNC;
    endcase
  endfunction : check_req

  function automatic logic [6:0] data_beats(input logic [7:0] f, input logic [15:0] q);
    unique case (f)
      `FC_READ_COILS, `FC_READ_INPUTS: data_beats = 7'h01;
      `FC_READ_HOLD: data_beats = q[6:0];
      default: data_beats = 7'h02;
    endcase
  endfunction : data_beats

  // ****************************************
  // state
  // ****************************************
  hstate_t s_reg;
  hstate_t s_next;
  logic take;
  logic last_beat;
  logic [15:0] rd_addr;
  logic [15:0] rd_data;

  hold_regs u_hold (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(s_reg.wr_en),
    .wr_addr(s_reg.wr_addr),
    .wr_data(s_reg.wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // damaged or broadcast requests are swallowed without any trace
  assign take = req_valid && req_ready && !req_bad && !req_broadcast;
  assign rd_addr = s_reg.addr + {9'h000, s_reg.cnt};
  assign last_beat = (s_reg.cnt == data_beats(s_reg.func, s_reg.qty) - 7'h01);

  always_comb begin
    s_next = s_reg;
    s_next.cmd_pulse = 1'b0;
    s_next.wr_en = 1'b0;
    unique case (s_reg.state)
      ST_IDLE: begin
        if (take) begin
          s_next.func = req_func;
          s_next.addr = req_addr;
          s_next.qty = req_qty;
          s_next.val = req_value;
          s_next.cnt = 7'h00;
          s_next.exc = check_req(req_func, req_addr, req_qty, req_value);
          s_next.state = ST_HDR;
          if (s_next.exc == `EXC_NONE) begin
            unique case (req_func)
              `FC_WRITE_REGS: s_next.state = ST_WREGS;
              `FC_WRITE_COILS: s_next.state = ST_WCOILS;
              `FC_WRITE_COIL: begin
                s_next.cmd_pulse = (req_value == `COIL_ON);
                s_next.cmd_coil = req_addr;
              end
              `FC_WRITE_REG: begin
                s_next.wr_en = 1'b1;
                s_next.wr_addr = req_addr;
                s_next.wr_data = req_value;
              end
              default: s_next.state = ST_HDR;
            endcase
          end
        end
      end
      ST_WREGS: begin
        if (dat_valid) begin
          s_next.wr_en = 1'b1;
          s_next.wr_addr = rd_addr;
          s_next.wr_data = dat_word;
          if (s_reg.cnt == s_reg.qty[6:0] - 7'h01) begin
            s_next.cnt = 7'h00;
            s_next.state = ST_HDR;
          end else begin
            s_next.cnt = s_reg.cnt + 7'h01;
          end
        end
      end
      ST_WCOILS: begin
        // only the lowest coil of the sequence counts; the rest are dropped
        if (dat_valid) begin
          s_next.cmd_pulse = dat_word[0];
          s_next.cmd_coil = s_reg.addr;
          s_next.state = ST_HDR;
        end
      end
      ST_HDR: begin
        if (rsp_ready) begin
          s_next.state = (s_reg.exc != `EXC_NONE) ? ST_IDLE : ST_DATA;
        end
      end
      ST_DATA: begin
        if (rsp_ready) begin
          if (last_beat) begin
            s_next.state = ST_IDLE;
            s_next.cnt = 7'h00;
          end else begin
            s_next.cnt = s_reg.cnt + 7'h01;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign req_ready = (s_reg.state == ST_IDLE);
  assign dat_ready = (s_reg.state == ST_WREGS) || (s_reg.state == ST_WCOILS);
  assign rsp_valid = (s_reg.state == ST_HDR) || (s_reg.state == ST_DATA);
  assign rsp_hdr = (s_reg.state == ST_HDR);
  assign rsp_last = ((s_reg.state == ST_HDR) && (s_reg.exc != `EXC_NONE)) ||
                    ((s_reg.state == ST_DATA) && last_beat);
  assign cmd_pulse = s_reg.cmd_pulse;
  assign cmd_coil = s_reg.cmd_coil;

  always_comb begin
    rsp_word = 16'h0000;
    if (s_reg.state == ST_HDR) begin
      if (s_reg.exc != `EXC_NONE) rsp_word = {s_reg.func | `EXC_FLAG, s_reg.exc};
      else rsp_word = {s_reg.func, `EXC_NONE};
    end else if (s_reg.state == ST_DATA) begin
      unique case (s_reg.func)
        `FC_READ_COILS, `FC_READ_INPUTS: rsp_word = 16'h0000;
        `FC_READ_HOLD: rsp_word = rd_data;
        `FC_WRITE_COILS, `FC_WRITE_REGS: rsp_word = (s_reg.cnt == 7'h00) ? s_reg.addr : s_reg.qty;
        default: rsp_word = (s_reg.cnt == 7'h00) ? s_reg.addr : s_reg.val;
      endcase
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_coil_zero;
    (rsp_valid && !rsp_hdr && ((s_reg.func == `FC_READ_COILS) || (s_reg.func == `FC_READ_INPUTS)))
      |-> (rsp_word == 16'h0000) && rsp_last;
  endproperty
  a_coil_zero: assert property (p_coil_zero) else $error("bit read answered nonzero");

  property p_hold_count;
    (rsp_valid && !rsp_hdr && rsp_last && (s_reg.func == `FC_READ_HOLD)) |-> (s_reg.cnt == s_reg.qty[6:0] - 7'h01);
  endproperty
  a_hold_count: assert property (p_hold_count) else $error("register read count wrong");

  property p_coil_on;
    (take && (req_func == `FC_WRITE_COIL) && (req_value == `COIL_ON))
      |=> cmd_pulse && (cmd_coil == $past(req_addr)) ##1 !cmd_pulse;
  endproperty
  a_coil_on: assert property (p_coil_on) else $error("coil on gave no command");

  property p_coil_off;
    (take && (req_func == `FC_WRITE_COIL) && (req_value == `COIL_OFF)) |=> !cmd_pulse ##0 rsp_hdr;
  endproperty
  a_coil_off: assert property (p_coil_off) else $error("coil off misbehaved");

  property p_reg_write;
    (take && (req_func == `FC_WRITE_REG)) |=> s_reg.wr_en && (s_reg.wr_addr == $past(req_addr));
  endproperty
  a_reg_write: assert property (p_reg_write) else $error("single write not stored");

  property p_loopback;
    (rsp_valid && !rsp_hdr && (s_reg.func == `FC_DIAG) && (s_reg.cnt == 7'h01))
      |-> rsp_last && (rsp_word == s_reg.val);
  endproperty
  a_loopback: assert property (p_loopback) else $error("loop-back echo wrong");

  property p_first_coil;
    (dat_valid && dat_ready && (s_reg.state == ST_WCOILS)) |=> (cmd_pulse == $past(dat_word[0])) && rsp_hdr;
  endproperty
  a_first_coil: assert property (p_first_coil) else $error("first coil not used");

  property p_silent;
    (req_valid && req_ready && (req_broadcast || req_bad)) |=> req_ready && !cmd_pulse && !s_reg.wr_en;
  endproperty
  a_silent: assert property (p_silent) else $error("dropped request acted on");

  property p_bad_func;
    (take && (check_req(req_func, 16'h0000, 16'h0001, `COIL_OFF) == `EXC_FUNC))
      |=> rsp_hdr && rsp_last && (rsp_word[7:0] == `EXC_FUNC);
  endproperty
  a_bad_func: assert property (p_bad_func) else $error("unknown function not refused");

  property p_too_many;
    (take && (req_func == `FC_READ_HOLD) && (req_qty > `MAX_REGS)) |=> rsp_hdr && (s_reg.exc == `EXC_VALUE);
  endproperty
  a_too_many: assert property (p_too_many) else $error("oversize read not refused");

  property p_input_zero;
    (rsp_valid && !rsp_hdr && (s_reg.func == `FC_READ_INPUTS)) |-> (rsp_word == 16'h0000) && rsp_last;
  endproperty
  a_input_zero: assert property (p_input_zero) else $error("input status answered nonzero");

  property p_multi_store;
    (dat_valid && (s_reg.state == ST_WREGS)) |=> s_reg.wr_en && (s_reg.wr_data == $past(dat_word));
  endproperty
  a_multi_store: assert property (p_multi_store) else $error("multiple write word not stored");

  // a refused request must leave no trace beyond its exception header
  property p_refused_inert;
    (take && (check_req(req_func, req_addr, req_qty, req_value) != `EXC_NONE))
      |=> rsp_hdr && rsp_last && !cmd_pulse && !s_reg.wr_en;
  endproperty
  a_refused_inert: assert property (p_refused_inert) else $error("refused request acted on");

  property p_bad_quiet;
    (req_valid && req_ready && req_bad) |=> !rsp_valid && !dat_ready;
  endproperty
  a_bad_quiet: assert property (p_bad_quiet) else $error("damaged request answered");

  c_hold_read: cover property (rsp_last && !rsp_hdr && (s_reg.func == `FC_READ_HOLD));
  c_command: cover property (cmd_pulse);
  c_exception: cover property (rsp_hdr && rsp_last && rsp_ready);
  c_multi_write: cover property (s_reg.state == ST_WREGS ##1 s_reg.state == ST_HDR);

endmodule : modbus_slave_function_handler

// ### modbus_master_model.sv
// Purpose: answer sink of the modbus master that sits opposite the function handler
// Assumes: answers arrive as a header beat then data beats, closed by rsp_last
// Notes: slow=1 drops rsp_ready every other cycle so answers see back-pressure
`timescale 1ns/10ps
module modbus_master_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic rsp_valid,
  input wire logic rsp_hdr,
  input wire logic rsp_last,
  input wire logic [15:0] rsp_word,
  output logic rsp_ready
);
  // ****************************************
  // beat capture
  // ****************************************
  logic [15:0] got [$];
  int n_last;
  int bad_hdr;
  logic first;
  logic phase;

  initial begin
    rsp_ready = 1'b0;
    phase = 1'b0;
    first = 1'b1;
    n_last = 0;
    bad_hdr = 0;
  end

  // the first beat of every answer must be flagged as header, no other beat
  always @(posedge core_clk) begin
    if (rst !== 1'b1 && rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
      if (rsp_hdr !== first) begin
        bad_hdr++;
      end
      got.push_back(rsp_word);
      first = rsp_last;
      if (rsp_last === 1'b1) begin
        n_last++;
      end
    end
    phase <= ~phase;
    rsp_ready <= #1 (!slow || phase) && (rst !== 1'b1);
  end
endmodule : modbus_master_model

// ### tb.sv
// Purpose: self-checking bench of the modbus function handler
// Assumes: requests arrive decoded; the master model takes the answers
// Notes: quantities are kept legal except where a refusal is the point
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb;
  // ****************************************
  // signals and instances
  // ****************************************
  logic core_clk = 1'b0, rst = 1'b1, slow = 1'b0;
  logic req_valid = 1'b0, req_broadcast = 1'b0, req_bad = 1'b0, dat_valid = 1'b0;
  logic [7:0] req_func = 8'h00;
  logic [15:0] req_addr = 16'h0000, req_qty = 16'h0000, req_value = 16'h0000, dat_word = 16'h0000;
  logic req_ready, dat_ready, rsp_valid, rsp_ready, rsp_hdr, rsp_last, cmd_pulse;
  logic [15:0] rsp_word, cmd_coil, last_coil;
  logic [15:0] wq [$];
  int num_errors = 0, n_checks = 0, n_pulse = 0;

  modbus_slave_function_handler DUT (.core_clk(core_clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_func(req_func), .req_addr(req_addr), .req_qty(req_qty),
    .req_value(req_value), .req_broadcast(req_broadcast), .req_bad(req_bad), .dat_valid(dat_valid),
    .dat_ready(dat_ready), .dat_word(dat_word), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_hdr(rsp_hdr), .rsp_last(rsp_last), .rsp_word(rsp_word), .cmd_pulse(cmd_pulse), .cmd_coil(cmd_coil));
  modbus_master_model m (.core_clk(core_clk), .rst(rst), .slow(slow), .rsp_valid(rsp_valid),
    .rsp_hdr(rsp_hdr), .rsp_last(rsp_last), .rsp_word(rsp_word), .rsp_ready(rsp_ready));

  always #10 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (cmd_pulse === 1'b1) begin
      n_pulse++;
      last_coil = cmd_coil;
    end
  end

  // ****************************************
  // bus tasks
  // ****************************************
  task automatic req(input logic [7:0] f, input logic [15:0] a, q, v, input logic bc, bad);
    int t;
    @(posedge core_clk);
    #1;
    req_valid = 1'b1; req_func = f; req_addr = a; req_qty = q; req_value = v;
    req_broadcast = bc; req_bad = bad;
    t = 0;
    do begin @(posedge core_clk); t++; end while (req_ready !== 1'b1 && t < 100);
    #1 req_valid = 1'b0;
  endtask : req

  task automatic dat(input logic [15:0] w);
    int t;
    @(posedge core_clk);
    #1;
    dat_valid = 1'b1; dat_word = w;
    t = 0;
    do begin @(posedge core_clk); t++; end while (dat_ready !== 1'b1 && t < 100);
    #1 dat_valid = 1'b0;
  endtask : dat

  // one request, its data words from wq, then the whole answer compared
  task automatic run(input logic [7:0] f, input logic [15:0] a, q, v, input int n,
      input logic [15:0] w0, w1 = 16'h0000, w2 = 16'h0000, w3 = 16'h0000);
    logic [15:0] e [4];
    int k;
    e = '{w0, w1, w2, w3};
    m.got.delete();
    k = m.n_last;
    req(f, a, q, v, 1'b0, 1'b0);
    foreach (wq[i]) dat(wq[i]);
    wq.delete();
    for (int t = 0; t < 300 && m.n_last == k; t++) @(posedge core_clk);
    #1;
    `CHK(m.got.size(), n)
    for (int i = 0; i < n && i < m.got.size(); i++) `CHK(m.got[i], e[i])
  endtask : run

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_bits;
    run(8'h01, 16'h0000, 16'h0010, 16'h0000, 2, 16'h0100, 16'h0000);
    run(8'h02, 16'h0000, 16'h0010, 16'h0000, 2, 16'h0200, 16'h0000);
    $display("test bits done");
  endtask : t_bits

  task automatic t_regs;
    run(8'h06, 16'h0005, 16'h0000, 16'h1234, 3, 16'h0600, 16'h0005, 16'h1234);
    run(8'h03, 16'h0005, 16'h0002, 16'h0000, 3, 16'h0300, 16'h1234, 16'h0000);
    wq = '{16'ha1a1, 16'hb2b2, 16'hc3c3};
    run(8'h10, 16'h003e, 16'h0003, 16'h0000, 3, 16'h1000, 16'h003e, 16'h0003);
    run(8'h03, 16'h003e, 16'h0003, 16'h0000, 4, 16'h0300, 16'ha1a1, 16'hb2b2, 16'h0000);
    $display("test registers done");
  endtask : t_regs

  task automatic t_coils;
    int p;
    p = n_pulse;
    run(8'h05, 16'h0007, 16'h0000, 16'hff00, 3, 16'h0500, 16'h0007, 16'hff00);
    `CHK(n_pulse, p + 1)
    `CHK(last_coil, 16'h0007)
    run(8'h05, 16'h0008, 16'h0000, 16'h0000, 3, 16'h0500, 16'h0008, 16'h0000);
    run(8'h05, 16'h0008, 16'h0000, 16'h1234, 1, 16'h8503);
    `CHK(n_pulse, p + 1)
    wq = '{16'h0001};
    run(8'h0f, 16'h0003, 16'h0010, 16'h0000, 3, 16'h0f00, 16'h0003, 16'h0010);
    `CHK(n_pulse, p + 2)
    `CHK(last_coil, 16'h0003)
    wq = '{16'hfffe};
    run(8'h0f, 16'h0004, 16'h0010, 16'h0000, 3, 16'h0f00, 16'h0004, 16'h0010);
    `CHK(n_pulse, p + 2)
    $display("test coils done");
  endtask : t_coils

  task automatic t_diag;
    run(8'h08, 16'h0000, 16'h0005, 16'habcd, 3, 16'h0800, 16'h0000, 16'habcd);
    run(8'h08, 16'h0001, 16'h0001, 16'habcd, 1, 16'h8801);
    $display("test diagnostics done");
  endtask : t_diag

  task automatic t_refuse;
    logic [7:0] bad_fc [4];
    bad_fc = '{8'h04, 8'h07, 8'h11, 8'h2b};
    foreach (bad_fc[i]) run(bad_fc[i], 16'h0000, 16'h0001, 16'h0000, 1, {bad_fc[i] | 8'h80, 8'h01});
    run(8'h01, 16'h0000, 16'h0011, 16'h0000, 1, 16'h8103);
    run(8'h02, 16'h0000, 16'h0000, 16'h0000, 1, 16'h8203);
    run(8'h01, 16'h0001, 16'h0010, 16'h0000, 1, 16'h8102);
    run(8'h0f, 16'h0000, 16'h0011, 16'h0000, 1, 16'h8f03);
    run(8'h03, 16'h0000, 16'h007e, 16'h0000, 1, 16'h8303);
    run(8'h10, 16'h0000, 16'h007e, 16'h0000, 1, 16'h9003);
    $display("test refusals done");
  endtask : t_refuse

  // the master side never sends these in normal use; here they are forced on purpose
  task automatic t_drop;
    int k, p;
    k = m.n_last;
    p = n_pulse;
    req(8'h06, 16'h0009, 16'h0000, 16'h5555, 1'b1, 1'b0);
    req(8'h05, 16'h0002, 16'h0000, 16'hff00, 1'b0, 1'b1);
    repeat (10) @(posedge core_clk);
    #1;
    `CHK(m.n_last, k)
    `CHK(n_pulse, p)
    req_broadcast = 1'b0;
    req_bad = 1'b0;
    run(8'h03, 16'h0009, 16'h0001, 16'h0000, 2, 16'h0300, 16'h0000);
    $display("test dropped requests done");
  endtask : t_drop

  // ****************************************
  // sequence and verdict
  // ****************************************
  task automatic tally_and_finish;
    `CHK(m.bad_hdr, 0)
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (6) @(posedge core_clk);
    #1 rst = 1'b0;
    `CHK(req_ready, 1'b1)
    `CHK(rsp_valid, 1'b0)
    `CHK(cmd_pulse, 1'b0)
    t_bits();
    slow = 1'b1;
    t_regs();
    t_coils();
    slow = 1'b0;
    t_diag();
    t_refuse();
    t_drop();
    tally_and_finish();
  end

  // the tests need well under 2000 cycles; a hang is cut at 20000
  initial begin
    #(20 * 20000);
    num_errors++;
    tally_and_finish();
  end
endmodule : tb
